// ==== src/gpio_pin_config_bank.sv ====
// Pin configuration bank: registers, pin muxing, combined interrupt routing
// What this block does
// - Bit0 one means input, zero output
// - Bit1 inverts logical sense of inputs and GPIO output
// - Bit7 one open-drain, zero push-pull
// - Group one bit2 joins combined interrupt one
// - Groups five/six bit5 join combined two
// - Groups five/six: bits4:3 select, 2,6 reserved
// - Group one: bit3 select, 6:4 reserved
// - Pin 1.3 function bit gives LED
// - Pin 1.4 function bit gives IR receive
// - Pin 1.5 function bit gives IR transmit
// - Pin 1.6 function bit gives motor-on
// - Pin 1.7 function bit gives drive select
// - Pin 5.0: clock, IRQ14, GPIO, reserved
// - Pin 5.2: density, GPIO, IRQ8, SMI
// - Pin 5.3: ROM select, IRQ11, GPIO, edge3
// - Pin 5.4: ROM enable, IRQ12, GPIO, edge4
// - Pin 6.0: keyboard data, IRQ1, GPIO, SMI
// - Most registers reset to 0x01
// - Pin 1.5 register resets to 0x00
// - Pin 5.2 register resets to 0x09
// - Combined interrupt routed by 4-bit map, zero off
// - Filter bit selects debounce or bypass
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module gpio_pin_config_bank
	import gpio_cfg_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// Register port
	input  wire logic [7:0]          regAddr,
	input  wire logic [7:0]          regWrData,
	input  wire logic                regWr,
	input  wire logic                regRd,
	output logic      [7:0]          regRdData,
	// Pins: input, output, output enable (low drives)
	input  wire logic [NPINS-1:0]    pinIn,
	output logic      [NPINS-1:0]    pinOut,
	output logic      [NPINS-1:0]    pinOeN,
	// Data value software drives and sees, in logical sense
	input  wire logic [NPINS-1:0]    gpioOutData,
	output logic      [NPINS-1:0]    gpioInData,
	// Alternate function outputs into the pin
	input  wire logic                ledDrive,
	input  wire logic                infrared_transmit_2,
	input  wire logic                floppy_motor_on_1,
	input  wire logic                floppy_drive_select_1,
	input  wire logic                floppy_density_select_1,
	input  wire logic                bios_rom_chip_select,
	input  wire logic                bios_rom_output_enable,
	input  wire logic                system_mgmt_interrupt_out,
	// Alternate function inputs taken from the pin
	output logic                     infrared_receive_2,
	output logic                     pciClockIn,
	output logic                     keyboard_data_bit0,
	output logic      [15:0]         isaIrqPin,
	output logic      [4:3]          eitherEdgeIrq,
	// Combined interrupts onto ISA lines
	output logic      [15:0]         combinedIrq
);
	import gpio_cfg_pkg::*;

	typedef struct packed {
		logic [NPINS-1:0][7:0] cfg;
		logic [7:0]            int1;
		logic [7:0]            int2;
		logic [NPINS-1:0]      sync1;
		logic [NPINS-1:0]      sync2;
		logic [NPINS-1:0]      prev;
		logic [NPINS-1:0]      filt;
		logic [NPINS-1:0][15:0] cnt;
		logic [7:0]            rd;
		logic [15:0]           irq;
		logic [NPINS-1:0]      pout;
		logic [NPINS-1:0]      poe;
		logic [NPINS-1:0]      gin;
		logic                  irrx;
		logic                  pclk;
		logic                  kbd;
		logic [15:0]           isa;
		logic [4:3]            edg;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Offset lookup per slot
	function automatic logic [7:0] slotOfs(input int i);
		case (i)
			SLOT_1_3: slotOfs = OFS_1_3;
			SLOT_1_4: slotOfs = OFS_1_4;
			SLOT_1_5: slotOfs = OFS_1_5;
			SLOT_1_6: slotOfs = OFS_1_6;
			SLOT_1_7: slotOfs = OFS_1_7;
			SLOT_5_0: slotOfs = OFS_5_0;
			SLOT_5_2: slotOfs = OFS_5_2;
			SLOT_5_3: slotOfs = OFS_5_3;
			SLOT_5_4: slotOfs = OFS_5_4;
			default:  slotOfs = OFS_6_0;
		endcase
	endfunction

	// Group one slots have single-bit select
	function automatic logic isG1(input int i);
		isG1 = (i <= SLOT_1_7);
	endfunction

	// Map code to one-hot ISA line; code zero and one invalid code give nothing
	function automatic logic [15:0] irqMap(input logic [3:0] code, input logic act);
		irqMap = 16'h0000;
		if (act && code != 4'h0 && code != 4'h2) begin
			irqMap[code] = 1'b1;
		end
	endfunction

	always_comb begin
		logic [NPINS-1:0] drv;
		logic [NPINS-1:0] useGpio;
		logic [NPINS-1:0] logicIn;
		logic [NPINS-1:0] src;
		logic [1:0]       fs;
		logic             g1Any;
		logic             g2Any;
		drv = '0;
		useGpio = '0;
		logicIn = '0;
		src = '0;
		fs = F00;
		g1Any = 1'b0;
		g2Any = 1'b0;
		s_d = s_q;
		// Two-stage synchroniser on pins
		s_d.sync1 = pinIn;
		s_d.sync2 = s_q.sync1;
		// Register writes; reserved bits masked off
		if (regWr) begin
			for (int i = 0; i < NPINS; i++) begin
				if (regAddr == slotOfs(i)) begin
					s_d.cfg[i] = regWrData & (isG1(i) ? MASK_G1 : MASK_G5);
				end
			end
			if (regAddr == OFS_INT1) begin
				s_d.int1 = regWrData & MASK_INT;
			end
			if (regAddr == OFS_INT2) begin
				s_d.int2 = regWrData & MASK_INT;
			end
		end
		// Read data, valid only the cycle after the strobe
		s_d.rd = 8'h00;
		if (regRd) begin
			for (int i = 0; i < NPINS; i++) begin
				if (regAddr == slotOfs(i)) begin
					s_d.rd = s_q.cfg[i];
				end
			end
			if (regAddr == OFS_INT1) begin
				s_d.rd = s_q.int1;
			end
			if (regAddr == OFS_INT2) begin
				s_d.rd = s_q.int2;
			end
			if (regAddr == OFS_STATUS) begin
				s_d.rd = s_q.gin[7:0];
			end
		end
		// Per-pin function choice and driven value
		for (int i = 0; i < NPINS; i++) begin
			fs = s_q.cfg[i][BIT_FSEL +: 2];
			logicIn[i] = s_q.sync2[i] ^ s_q.cfg[i][BIT_POL];
			src[i] = gpioOutData[i];
			useGpio[i] = 1'b1;
			if (isG1(i) && s_q.cfg[i][BIT_FSEL]) begin
				useGpio[i] = 1'b0;
				case (i)
					SLOT_1_3: src[i] = ledDrive;
					SLOT_1_5: src[i] = infrared_transmit_2;
					SLOT_1_6: src[i] = floppy_motor_on_1;
					SLOT_1_7: src[i] = floppy_drive_select_1;
					default:  src[i] = 1'b1;                  // Receive pin sources a constant high
				endcase
			end
			if (!isG1(i)) begin
				useGpio[i] = (i == SLOT_5_2) ? (fs == F01) : (fs == F10);
				case (i)
					SLOT_5_2: if (fs == F00) src[i] = floppy_density_select_1;
						else if (fs == F11) src[i] = system_mgmt_interrupt_out;
					SLOT_5_3: if (fs == F00) src[i] = bios_rom_chip_select;
					SLOT_5_4: if (fs == F00) src[i] = bios_rom_output_enable;
					SLOT_6_0: if (fs == F11) src[i] = system_mgmt_interrupt_out;
					default: ;
				endcase
			end
			// Output when direction bit clear, GPIO inverted by polarity
			drv[i] = !s_q.cfg[i][BIT_DIR];
			if (useGpio[i]) begin
				src[i] = gpioOutData[i] ^ s_q.cfg[i][BIT_POL];
			end
			// Open drain drives only low, releases for high
			s_d.pout[i] = s_q.cfg[i][BIT_OD] ? 1'b0 : src[i];
			s_d.poe[i] = !(drv[i] && (!s_q.cfg[i][BIT_OD] || !src[i]));
			s_d.gin[i] = logicIn[i];
		end
		// Alternate inputs taken from pins
		s_d.irrx = s_q.cfg[SLOT_1_4][BIT_FSEL] && logicIn[SLOT_1_4];
		s_d.pclk = (s_q.cfg[SLOT_5_0][BIT_FSEL +: 2] == F00) && logicIn[SLOT_5_0];
		s_d.kbd = (s_q.cfg[SLOT_6_0][BIT_FSEL +: 2] == F00) && logicIn[SLOT_6_0];
		s_d.isa = 16'h0000;
		s_d.isa[14] = (s_q.cfg[SLOT_5_0][BIT_FSEL +: 2] == F01) && logicIn[SLOT_5_0];
		s_d.isa[8] = (s_q.cfg[SLOT_5_2][BIT_FSEL +: 2] == F10) && logicIn[SLOT_5_2];
		s_d.isa[11] = (s_q.cfg[SLOT_5_3][BIT_FSEL +: 2] == F01) && logicIn[SLOT_5_3];
		s_d.isa[12] = (s_q.cfg[SLOT_5_4][BIT_FSEL +: 2] == F01) && logicIn[SLOT_5_4];
		s_d.isa[1] = (s_q.cfg[SLOT_6_0][BIT_FSEL +: 2] == F01) && logicIn[SLOT_6_0];
		// Either-edge interrupts pulse on any change of the synced pin
		s_d.prev = s_q.sync2;
		s_d.edg[3] = (s_q.cfg[SLOT_5_3][BIT_FSEL +: 2] == F11) && (s_q.sync2[SLOT_5_3] != s_q.prev[SLOT_5_3]);
		s_d.edg[4] = (s_q.cfg[SLOT_5_4][BIT_FSEL +: 2] == F11) && (s_q.sync2[SLOT_5_4] != s_q.prev[SLOT_5_4]);
		// Debounce: take new level only after it stands for the full count
		for (int i = 0; i < NPINS; i++) begin
			if (logicIn[i] == s_q.filt[i]) begin
				s_d.cnt[i] = 16'h0000;
			end else if (s_q.cnt[i] >= 16'(DEBOUNCE_CYCLES - 1)) begin
				s_d.cnt[i] = 16'h0000;
				s_d.filt[i] = logicIn[i];
			end else begin
				s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
			end
		end
		// Combined interrupts from the enabled group members
		for (int i = 0; i < NPINS; i++) begin
			if (isG1(i)) begin
				g1Any = g1Any | (s_q.cfg[i][BIT_GRP1] &
					(s_q.int1[BIT_FILT] ? s_q.filt[i] : logicIn[i]));
			end else begin
				g2Any = g2Any | (s_q.cfg[i][BIT_GRP2] &
					(s_q.int2[BIT_FILT] ? s_q.filt[i] : logicIn[i]));
			end
		end
		s_d.irq = irqMap(s_q.int1[7:4], g1Any) | irqMap(s_q.int2[7:4], g2Any);
		// Synchronous reset loads the documented defaults
		if (rst) begin
			s_d = '0;
			for (int i = 0; i < NPINS; i++) begin
				s_d.cfg[i] = RST_CFG;
			end
			s_d.cfg[SLOT_1_5] = RST_1_5;
			s_d.cfg[SLOT_5_2] = RST_5_2;
			s_d.int1 = RST_INT;
			s_d.int2 = RST_INT;
			s_d.poe = '1;
		end
	end

	always_ff @(posedge clk_sys) begin
		s_q <= s_d;
	end

	// Outputs straight from flip-flops
	assign regRdData = s_q.rd;
	assign pinOut = s_q.pout;
	assign pinOeN = s_q.poe;
	assign gpioInData = s_q.gin;
	assign infrared_receive_2 = s_q.irrx;
	assign pciClockIn = s_q.pclk;
	assign keyboard_data_bit0 = s_q.kbd;
	assign isaIrqPin = s_q.isa;
	assign eitherEdgeIrq = s_q.edg;
	assign combinedIrq = s_q.irq;

	// Checks
	property p_resetVal;
		@(posedge clk_sys) $fell(rst) |-> s_q.cfg[SLOT_1_5] == 8'h00 && s_q.cfg[SLOT_5_2] == 8'h09 && s_q.cfg[SLOT_1_4] == 8'h01;
	endproperty
	a_resetVal: assert property (p_resetVal) else $error("bad reset value");

	property p_rsvd;
		@(posedge clk_sys) disable iff (rst) regWr && regAddr == OFS_5_0 |=> s_q.cfg[SLOT_5_0][6] == 1'b0 && s_q.cfg[SLOT_5_0][2] == 1'b0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit stored");

	property p_rd;
		@(posedge clk_sys) disable iff (rst) regRd && regAddr == OFS_1_6 |=> regRdData == $past(s_q.cfg[SLOT_1_6]);
	endproperty
	a_rd: assert property (p_rd) else $error("read data wrong");

	property p_input;
		@(posedge clk_sys) disable iff (rst) s_q.cfg[SLOT_1_6][BIT_DIR] |=> pinOeN[SLOT_1_6];
	endproperty
	a_input: assert property (p_input) else $error("input pin driven");

	property p_od;
		@(posedge clk_sys) disable iff (rst) s_q.cfg[SLOT_1_7][BIT_OD] |=> !pinOut[SLOT_1_7];
	endproperty
	a_od: assert property (p_od) else $error("open drain drove high");

	property p_pol;
		@(posedge clk_sys) disable iff (rst) $stable(s_q.cfg[SLOT_1_4][BIT_POL]) |=> gpioInData[SLOT_1_4] == ($past(s_q.sync2[SLOT_1_4]) ^ $past(s_q.cfg[SLOT_1_4][BIT_POL]));
	endproperty
	a_pol: assert property (p_pol) else $error("polarity wrong");

	property p_irq14;
		@(posedge clk_sys) disable iff (rst) isaIrqPin[14] |-> $past(s_q.cfg[SLOT_5_0][4:3]) == 2'h1;
	endproperty
	a_irq14: assert property (p_irq14) else $error("irq14 without select");

	property p_map;
		@(posedge clk_sys) disable iff (rst) s_q.int1[7:4] == 4'h0 && s_q.int2[7:4] == 4'h0 |=> combinedIrq == 16'h0000;
	endproperty
	a_map: assert property (p_map) else $error("disabled irq active");
endmodule

// ==== pkg/gpio_cfg_pkg.sv ====
// Package with offsets, field positions and reset values of the pin configuration bank
package gpio_cfg_pkg;
	localparam int NPINS = 10;
	// Pin slots: 0..4 group one (0 led 1.3, 1..4 are 1.4..1.7), 5..9 group five/six (5.0,5.2,5.3,5.4,6.0)
	localparam int SLOT_1_3 = 0;
	localparam int SLOT_1_4 = 1;
	localparam int SLOT_1_5 = 2;
	localparam int SLOT_1_6 = 3;
	localparam int SLOT_1_7 = 4;
	localparam int SLOT_5_0 = 5;
	localparam int SLOT_5_2 = 6;
	localparam int SLOT_5_3 = 7;
	localparam int SLOT_5_4 = 8;
	localparam int SLOT_6_0 = 9;
	localparam logic [7:0] OFS_1_3 = 8'hE3;
	localparam logic [7:0] OFS_1_4 = 8'hE4;
	localparam logic [7:0] OFS_1_5 = 8'hE5;
	localparam logic [7:0] OFS_1_6 = 8'hE6;
	localparam logic [7:0] OFS_1_7 = 8'hE7;
	localparam logic [7:0] OFS_5_0 = 8'hC8;
	localparam logic [7:0] OFS_5_2 = 8'hCA;
	localparam logic [7:0] OFS_5_3 = 8'hCB;
	localparam logic [7:0] OFS_5_4 = 8'hCC;
	localparam logic [7:0] OFS_6_0 = 8'hD0;
	localparam logic [7:0] OFS_INT2 = 8'hEF;
	localparam logic [7:0] OFS_INT1 = 8'hF0;
	localparam logic [7:0] OFS_STATUS = 8'hF1;
	// Field positions
	localparam int BIT_DIR = 0;
	localparam int BIT_POL = 1;
	localparam int BIT_GRP1 = 2;
	localparam int BIT_FSEL = 3;
	localparam int BIT_GRP2 = 5;
	localparam int BIT_OD = 7;
	localparam int BIT_FILT = 3;
	// Writable bit masks
	localparam logic [7:0] MASK_G1 = 8'h8F;
	localparam logic [7:0] MASK_G5 = 8'hBB;
	localparam logic [7:0] MASK_INT = 8'hF8;
	// Reset values
	localparam logic [7:0] RST_CFG = 8'h01;
	localparam logic [7:0] RST_1_5 = 8'h00;
	localparam logic [7:0] RST_5_2 = 8'h09;
	localparam logic [7:0] RST_INT = 8'h00;
	// Debounce time and cycles at 200 MHz
	localparam int DEBOUNCE_NS = 1000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Two-bit function codes
	localparam logic [1:0] F00 = 2'h0;
	localparam logic [1:0] F01 = 2'h1;
	localparam logic [1:0] F10 = 2'h2;
	localparam logic [1:0] F11 = 2'h3;
endpackage

// ==== sim/pin_board_model.sv ====
// Board model: resolves each pin from device drive, external drive and pull-up
`timescale 1ns/100ps
module pin_board_model (
	// Device side of each pin
	input  wire logic [gpio_cfg_pkg::NPINS-1:0] pinOut,
	input  wire logic [gpio_cfg_pkg::NPINS-1:0] pinOeN,
	// External driver on the board
	input  wire logic [gpio_cfg_pkg::NPINS-1:0] extEn,
	input  wire logic [gpio_cfg_pkg::NPINS-1:0] extVal,
	// Level seen at the pin
	output logic      [gpio_cfg_pkg::NPINS-1:0] pinIn
);
	import gpio_cfg_pkg::*;
	// Device wins while driving, then the external driver; an undriven pin floats up so no stale value lingers
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			pinIn[i] = !pinOeN[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'b1);
		end
	end
endmodule

// ==== sim/gpio_pin_config_bank_tb.sv ====
// Self-checking bench for the pin configuration bank
`timescale 1ns/100ps
module gpio_pin_config_bank_tb;
	import gpio_cfg_pkg::*;
	// Clock, reset and register port
	logic             clk_sys = 0;
	logic             rst = 1;
	logic [7:0]       regAddr = 0;
	logic [7:0]       regWrData = 0;
	logic             regWr = 0;
	logic             regRd = 0;
	logic [7:0]       regRdData;
	// Pins, data and alternate functions
	logic [NPINS-1:0] pinIn, pinOut, pinOeN, gpioInData;
	logic [NPINS-1:0] gpioOutData = 0, extEn = 0, extVal = 0;
	logic [7:0]       altSrc = 0;
	logic             irRx, pciClk, kbdData;
	logic [15:0]      isaIrqPin, combinedIrq;
	logic [4:3]       edgeIrq;
	logic [18:0]      altSeen;
	int               miscompares = 0, n_checks = 0, s, n;
	logic [7:0]       r;
	logic [7:0]       ofs [NPINS] = '{OFS_1_3, OFS_1_4, OFS_1_5, OFS_1_6, OFS_1_7,
		OFS_5_0, OFS_5_2, OFS_5_3, OFS_5_4, OFS_6_0};
	logic [7:0]       gsel [NPINS] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h08, 8'h10, 8'h10, 8'h10};
	// Alternate cases: slot, config, drives pin, source or seen index
	int               altTab [17][4] = '{'{0, 8, 1, 0}, '{2, 8, 1, 1}, '{3, 8, 1, 2}, '{4, 8, 1, 3},
		'{6, 0, 1, 4}, '{6, 24, 1, 7}, '{7, 0, 1, 5}, '{8, 0, 1, 6}, '{9, 24, 1, 7},
		'{1, 9, 0, 0}, '{5, 1, 0, 1}, '{5, 9, 0, 17}, '{6, 17, 0, 11}, '{7, 9, 0, 14},
		'{8, 9, 0, 15}, '{9, 1, 0, 2}, '{9, 9, 0, 4}};
	assign altSeen = {isaIrqPin, kbdData, pciClk, irRx};
	// Short debounce keeps filtered waits brief
	gpio_pin_config_bank #(.DEBOUNCE_CYCLES(2)) dut_u (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .pinIn(pinIn),
		.pinOut(pinOut), .pinOeN(pinOeN), .gpioOutData(gpioOutData), .gpioInData(gpioInData),
		.ledDrive(altSrc[0]), .infrared_transmit_2(altSrc[1]), .floppy_motor_on_1(altSrc[2]),
		.floppy_drive_select_1(altSrc[3]), .floppy_density_select_1(altSrc[4]),
		.bios_rom_chip_select(altSrc[5]), .bios_rom_output_enable(altSrc[6]),
		.system_mgmt_interrupt_out(altSrc[7]), .infrared_receive_2(irRx), .pciClockIn(pciClk),
		.keyboard_data_bit0(kbdData), .isaIrqPin(isaIrqPin), .eitherEdgeIrq(edgeIrq), .combinedIrq(combinedIrq));
	pin_board_model board_u (.pinOut(pinOut), .pinOeN(pinOeN), .extEn(extEn), .extVal(extVal), .pinIn(pinIn));
	// 200 MHz clock
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Hang guard, far beyond the roughly 1200 cycles the run needs
	initial begin
		#(20000 * 5);
		miscompares++;
		end_sim();
	end
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic cyc(int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rdc(string what, logic [7:0] a, logic [7:0] exp);
		@(posedge clk_sys);
		regRd <= 1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 0;
		#1;
		chk(what, exp, regRdData);
	endtask
	task automatic doReset();
		rst <= 1;
		cyc(8);
		rst <= 0;
		cyc(4);
		for (int i = 0; i < NPINS; i++) begin
			rdc("cfg reset", ofs[i], i == SLOT_1_5 ? RST_1_5 : i == SLOT_5_2 ? RST_5_2 : RST_CFG);
		end
		rdc("int1 reset", OFS_INT1, RST_INT);
		chk("oe reset", 16'h03FB, pinOeN);
	endtask
	task automatic cmb(logic [7:0] io, logic [7:0] iv, int sl, logic [7:0] cv, logic [15:0] exp);
		wr(io, iv);
		wr(ofs[sl], cv);
		extVal[sl] <= 0;
		cyc(10);
		chk("combined idle", 16'h0000, combinedIrq);
		extVal[sl] <= 1;
		cyc(10);
		chk("combined", exp, combinedIrq);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		r = $urandom(32'hB809);
		doReset();
		wr(8'h00, 8'hFF);
		rdc("unmapped", 8'h00, 8'h00);
		for (int i = 0; i < NPINS; i++) begin
			r = 8'($urandom);
			wr(ofs[i], r);
			rdc("cfg rw", ofs[i], r & (i < SLOT_5_0 ? MASK_G1 : MASK_G5));
		end
		wr(OFS_INT2, 8'hFF);
		rdc("int2 rw", OFS_INT2, MASK_INT);
		// Every pin as plain GPIO: drive, invert, open drain, input
		for (int i = 0; i < NPINS; i++) begin
			gpioOutData <= 10'($urandom);
			wr(ofs[i], gsel[i]);
			cyc(3);
			chk("push-pull", {1'b0, gpioOutData[i]}, {pinOeN[i], pinOut[i]});
			wr(ofs[i], gsel[i] | 8'h02);
			cyc(3);
			chk("invert out", {1'b0, ~gpioOutData[i]}, {pinOeN[i], pinOut[i]});
			wr(ofs[i], gsel[i] | 8'h80);
			cyc(3);
			chk("open drain", {gpioOutData[i], 1'b0}, {pinOeN[i], pinOut[i]});
			extEn[i] <= 1;
			extVal[i] <= 1'($urandom);
			wr(ofs[i], gsel[i] | 8'h01);
			cyc(10);
			chk("input", {1'b1, extVal[i]}, {pinOeN[i], gpioInData[i]});
			wr(ofs[i], gsel[i] | 8'h03);
			cyc(10);
			chk("invert in", {1'b1, ~extVal[i]}, {pinOeN[i], gpioInData[i]});
			extEn[i] <= 0;
		end
		// Alternate functions: inputs at both pin levels, outputs from random sources
		for (int i = 0; i < 17; i++) begin
			s = altTab[i][0];
			for (int k = 0; k < 2; k++) begin
				altSrc <= 8'($urandom);
				extEn[s] <= !altTab[i][2];
				extVal[s] <= k[0];
				wr(ofs[s], 8'(altTab[i][1]));
				cyc(10);
				if (altTab[i][2] == 1) chk("alt out", {1'b0, altSrc[altTab[i][3]]}, {pinOeN[s], pinOut[s]});
				else chk("alt in", k[0], altSeen[altTab[i][3]]);
			end
		end
		// One pulse per pin edge, rising and falling
		for (int e = 3; e < 5; e++) begin
			s = e + 4;
			extEn[s] <= 1;
			wr(ofs[s], 8'h19);
			for (int k = 0; k < 2; k++) begin
				cyc(10);
				n = 0;
				extVal[s] <= ~extVal[s];
				repeat (12) begin
					cyc(1);
					n += (edgeIrq[e] === 1'b1);
				end
				chk("edge pulses", 16'h0001, 16'(n));
			end
		end
		// Second reset after traffic, then combined interrupts
		extEn <= 0;
		doReset();
		extEn <= 10'h3FF;
		extVal <= 0;
		cmb(OFS_INT1, 8'h30, SLOT_1_4, 8'h05, 16'h0008);
		cmb(OFS_INT1, 8'hF8, SLOT_1_4, 8'h05, 16'h8000);
		cmb(OFS_INT1, 8'h10, SLOT_1_4, 8'h05, 16'h0002);
		cmb(OFS_INT1, 8'h30, SLOT_1_4, 8'h01, 16'h0000);
		cmb(OFS_INT1, 8'h00, SLOT_1_4, 8'h05, 16'h0000);
		cmb(OFS_INT2, 8'h50, SLOT_5_0, 8'h31, 16'h0020);
		cmb(OFS_INT2, 8'h50, SLOT_5_0, 8'h11, 16'h0000);
		end_sim();
	end
endmodule
